// ==== src/cond_branch_pkg.sv ====
// Purpose: shared constants and types for the conditional skip/branch unit
// Assumes: 8-bit core, word-addressed program counter
// Notes: flag positions follow the status flags register layout C,Z,N,V,S,H,T,I
package cond_branch_pkg;
   localparam int PC_WIDTH = 12;
   localparam int OFFSET_WIDTH = 7;
   localparam logic [2:0] FLAG_C = 3'h0;
   localparam logic [2:0] FLAG_N = 3'h2;
   localparam logic [2:0] FLAG_V = 3'h3;
   localparam logic [2:0] FLAG_H = 3'h5;
   localparam logic [1:0] SKIP_ONE_WORD = 2'h2;
   localparam logic [1:0] SKIP_TWO_WORD = 2'h3;
   localparam logic [1:0] STEP_WORDS = 2'h1;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   typedef enum logic [3:0] {
      OP_NONE,
      OP_SKIP_REG_BIT_CLEAR,
      OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR,
      OP_SKIP_IO_BIT_SET,
      OP_BRANCH_FLAG_SET,
      OP_BRANCH_FLAG_CLEAR,
      OP_BRANCH_NO_CARRY,
      OP_BRANCH_UNSIGNED_GE,
      OP_BRANCH_SIGNED_GE,
      OP_BRANCH_SIGNED_LT,
      OP_BRANCH_HALF_CARRY
   } branch_op_t;
endpackage : cond_branch_pkg

// ==== src/cond_eval_if.sv ====
// Purpose: carries condition request and verdict between evaluator and top
// Assumes: single clock domain
// Notes: purely combinational signals
`timescale 1ns/10ps
`default_nettype none
interface cond_eval_if;
   cond_branch_pkg::branch_op_t op;
   logic [7:0] operand;
   logic [2:0] bitSel;
   logic [7:0] flags;
   logic taken;
   logic isSkip;
   modport requester (output op, output operand, output bitSel, output flags,
      input taken, input isSkip);
   modport evaluator (input op, input operand, input bitSel, input flags,
      output taken, output isSkip);
endinterface : cond_eval_if
`default_nettype wire

// ==== src/cond_evaluator.sv ====
// Purpose: decides whether a skip or branch condition holds
// Assumes: operand already holds the tested register or I/O register byte
// Notes: combinational only
`timescale 1ns/10ps
`default_nettype none
module cond_evaluator (
   cond_eval_if.evaluator ev
);
   logic bitVal;
   logic flagVal;
   logic signedLess;
   always_comb begin
      bitVal = ev.operand[ev.bitSel];
      flagVal = ev.flags[ev.bitSel];
      // signed compare as n xor v
      signedLess = ev.flags[cond_branch_pkg::FLAG_N] ^ ev.flags[cond_branch_pkg::FLAG_V];
      ev.isSkip = 1'b0;
      ev.taken = 1'b0;
      case (ev.op)
         cond_branch_pkg::OP_SKIP_REG_BIT_CLEAR: begin
            ev.isSkip = 1'b1;
            ev.taken = ~bitVal;
         end
         cond_branch_pkg::OP_SKIP_REG_BIT_SET: begin
            ev.isSkip = 1'b1;
            ev.taken = bitVal;
         end
         cond_branch_pkg::OP_SKIP_IO_BIT_CLEAR: begin
            ev.isSkip = 1'b1;
            ev.taken = ~bitVal;
         end
         cond_branch_pkg::OP_SKIP_IO_BIT_SET: begin
            ev.isSkip = 1'b1;
            ev.taken = bitVal;
         end
         cond_branch_pkg::OP_BRANCH_FLAG_SET: ev.taken = flagVal;
         cond_branch_pkg::OP_BRANCH_FLAG_CLEAR: ev.taken = ~flagVal;
         cond_branch_pkg::OP_BRANCH_NO_CARRY: ev.taken = ~ev.flags[cond_branch_pkg::FLAG_C];
         cond_branch_pkg::OP_BRANCH_UNSIGNED_GE: ev.taken = ~ev.flags[cond_branch_pkg::FLAG_C];
         cond_branch_pkg::OP_BRANCH_SIGNED_GE: ev.taken = ~signedLess;
         cond_branch_pkg::OP_BRANCH_SIGNED_LT: ev.taken = signedLess;
         cond_branch_pkg::OP_BRANCH_HALF_CARRY: ev.taken = ev.flags[cond_branch_pkg::FLAG_H];
         default: begin
            ev.isSkip = 1'b0;
            ev.taken = 1'b0;
         end
      endcase
   end
endmodule : cond_evaluator
`default_nettype wire

// ==== src/cond_branch_skip_unit.sv ====
// Purpose: next program counter and cycle count for skip and branch ops
// Assumes: one request per idle cycle; next instruction length given by fetch
// Notes: done pulses in the cycle after the last cycle of the instruction
`timescale 1ns/10ps
`default_nettype none
module cond_branch_skip_unit #(
   parameter int PC_WIDTH = cond_branch_pkg::PC_WIDTH,
   parameter int OFFSET_WIDTH = cond_branch_pkg::OFFSET_WIDTH
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic start,
   input wire cond_branch_pkg::branch_op_t op,
   input wire logic [PC_WIDTH-1:0] pcIn,
   input wire logic [7:0] operand,
   input wire logic [2:0] bitSel,
   input wire logic [OFFSET_WIDTH-1:0] offset,
   input wire logic nextIsTwoWord,
   input wire logic [7:0] flagsIn,
   output logic busy,
   output logic done,
   output logic [PC_WIDTH-1:0] pcOut,
   output logic taken,
   output logic [7:0] flagsOut,
   output logic [1:0] cycles
);
   // ************************************************************
   // parameter checks
   // ************************************************************
   // the offset is sign-extended into the pc, so it may not be wider
   if (PC_WIDTH < OFFSET_WIDTH) begin : gOffsetTooWide
      $error("offset wider than program counter");
   end
   // wider program counters are not served by this core
   if (PC_WIDTH > 22) begin : gPcTooWide
      $error("program counter too wide");
   end
   // one sign bit and at least one magnitude bit are needed
   if (OFFSET_WIDTH < 2) begin : gOffsetTooNarrow
      $error("offset too narrow");
   end

   // ************************************************************
   // cycle counts
   // ************************************************************
   // an untaken test costs one cycle
   localparam logic [1:0] CYC_UNTAKEN = 2'h1;
   // a taken branch, or a skip over a one-word instruction
   localparam logic [1:0] CYC_TAKEN = 2'h2;
   // skipping a two-word instruction costs one more fetch
   localparam logic [1:0] CYC_LONG_SKIP = 2'h3;
   // cycles covered by the taking cycle and the first wait state
   localparam logic [1:0] CYC_FIRST_WAIT = 2'h2;
   // the wait counter runs down to this before done
   localparam logic [1:0] REMAIN_LAST = 2'h0;
   localparam logic [1:0] REMAIN_STEP = 2'h1;

   // ************************************************************
   // state and datapath registers
   // ************************************************************
   // only two states: results are known in the taking cycle,
   // the wait state just stretches the instruction's length
   typedef enum logic [1:0] {S_IDLE, S_WAIT} state_t;

   state_t state_reg, state_next;
   logic [1:0] remain_reg, remain_next;
   logic [PC_WIDTH-1:0] pc_reg, pc_next;
   logic taken_reg, taken_next;
   logic [7:0] flags_reg, flags_next;
   logic [1:0] cycles_reg, cycles_next;
   logic done_reg, done_next;
   logic [PC_WIDTH-1:0] offsetExt;
   logic [PC_WIDTH-1:0] pcStep;
   logic [PC_WIDTH-1:0] pcBranch;
   logic [PC_WIDTH-1:0] pcSkip;
   logic [1:0] needCycles;

   cond_eval_if ev();

   // ************************************************************
   // condition evaluation
   // ************************************************************
   assign ev.op = op;
   assign ev.operand = operand;
   assign ev.bitSel = bitSel;
   assign ev.flags = flagsIn;

   cond_evaluator uEval (
      .ev(ev)
   );

   // ************************************************************
   // target computation and sequencing
   // ************************************************************
   always_comb begin
      offsetExt = PC_WIDTH'($signed(offset));
      pcStep = pcIn + PC_WIDTH'(cond_branch_pkg::STEP_WORDS);
      pcBranch = pcStep + offsetExt;
      // skip length depends on the instruction being jumped over
      pcSkip = pcIn + PC_WIDTH'(nextIsTwoWord ? cond_branch_pkg::SKIP_TWO_WORD
                                              : cond_branch_pkg::SKIP_ONE_WORD);
      // cycle cost follows the outcome, not the opcode alone
      if (!ev.taken) begin
         needCycles = CYC_UNTAKEN;
      end else if (ev.isSkip && nextIsTwoWord) begin
         needCycles = CYC_LONG_SKIP;
      end else begin
         needCycles = CYC_TAKEN;
      end
   end

   // ************************************************************
   // next-state logic
   // ************************************************************
   // results are latched once, at the taking edge; requests seen
   // in the wait state are dropped so the held pc cannot move
   always_comb begin
      state_next = state_reg;
      remain_next = remain_reg;
      pc_next = pc_reg;
      taken_next = taken_reg;
      flags_next = flags_reg;
      cycles_next = cycles_reg;
      done_next = 1'b0;
      case (state_reg)
         S_IDLE: begin
            if (start && op != cond_branch_pkg::OP_NONE) begin
               taken_next = ev.taken;
               cycles_next = needCycles;
               flags_next = flagsIn;
               if (!ev.taken) begin
                  pc_next = pcStep;
               end else if (ev.isSkip) begin
                  pc_next = pcSkip;
               end else begin
                  pc_next = pcBranch;
               end
               if (needCycles == CYC_UNTAKEN) begin
                  done_next = 1'b1;
               end else begin
                  state_next = S_WAIT;
                  remain_next = needCycles - CYC_FIRST_WAIT;
               end
            end
         end
         S_WAIT: begin
            if (remain_reg == REMAIN_LAST) begin
               done_next = 1'b1;
               state_next = S_IDLE;
            end else begin
               remain_next = remain_reg - REMAIN_STEP;
            end
         end
         default: state_next = S_IDLE;
      endcase
   end

   // ************************************************************
   // register stage
   // ************************************************************
   // reset is synchronous; all results read as zero until the
   // first request is taken
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= S_IDLE;
         remain_reg <= 2'h0;
         pc_reg <= '0;
         taken_reg <= 1'b0;
         flags_reg <= cond_branch_pkg::FLAGS_RESET;
         cycles_reg <= 2'h0;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         remain_reg <= remain_next;
         pc_reg <= pc_next;
         taken_reg <= taken_next;
         flags_reg <= flags_next;
         cycles_reg <= cycles_next;
         done_reg <= done_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // busy is decoded from the state register, so a new request
   // may be given in the very cycle that done is high
   assign busy = (state_reg != S_IDLE);
   // done lasts one cycle; the result outputs hold until the
   // next taken request
   assign done = done_reg;
   assign pcOut = pc_reg;
   assign taken = taken_reg;
   assign flagsOut = flags_reg;
   assign cycles = cycles_reg;
endmodule : cond_branch_skip_unit
`default_nettype wire

// ==== test/cond_branch_skip_unit_properties.sv ====
// Purpose: timing and result checks on the skip/branch unit
// Assumes: one clock, synchronous reset
// Notes: bound to every instance of the unit
`timescale 1ns/10ps
`default_nettype none
module cond_branch_skip_unit_properties #(
   parameter int PC_WIDTH = 12,
   parameter int OFFSET_WIDTH = 7
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic start,
   input wire cond_branch_pkg::branch_op_t op,
   input wire logic [PC_WIDTH-1:0] pcIn,
   input wire logic [OFFSET_WIDTH-1:0] offset,
   input wire logic nextIsTwoWord,
   input wire logic [7:0] flagsIn,
   input wire logic busy,
   input wire logic done,
   input wire logic [PC_WIDTH-1:0] pcOut,
   input wire logic taken,
   input wire logic [7:0] flagsOut,
   input wire logic [1:0] cycles
);
   wire acc = start && !busy && op != cond_branch_pkg::OP_NONE;
   wire isBr = op >= cond_branch_pkg::OP_BRANCH_FLAG_SET;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_flags_kept: assert property (acc |=> flagsOut == $past(flagsIn))
      else $error("flags not kept");
   a_untaken_step: assert property (acc ##1 !taken |->
      pcOut == PC_WIDTH'($past(pcIn) + 1) && done && cycles == 2'h1) else $error("bad step");
   a_skip_length: assert property (acc && !isBr ##1 taken |->
      pcOut == PC_WIDTH'($past(pcIn) + cycles) && cycles == ($past(nextIsTwoWord) ? 2'h3 : 2'h2))
      else $error("bad skip");
   a_branch_target: assert property (acc && isBr ##1 taken |-> pcOut == PC_WIDTH'($past(pcIn)
      + 1 + {{(PC_WIDTH-OFFSET_WIDTH){$past(offset[OFFSET_WIDTH-1])}}, $past(offset)}))
      else $error("bad branch target");
   a_branch_time: assert property (acc && isBr ##1 taken |->
      cycles == 2'h2 && busy && !done ##1 done && !busy) else $error("bad branch timing");
   a_skip_time: assert property (acc ##1 cycles == 2'h3 |->
      busy ##1 busy ##1 done && !busy) else $error("bad skip timing");
   a_busy_refuse: assert property (busy |=> $stable(pcOut) && $stable(cycles))
      else $error("request taken while busy");
   a_signed_less: assert property (acc && op == cond_branch_pkg::OP_BRANCH_SIGNED_LT |=>
      taken == ($past(flagsIn[2]) ^ $past(flagsIn[3]))) else $error("bad signed test");
   a_carry_clear: assert property (acc && (op == cond_branch_pkg::OP_BRANCH_NO_CARRY ||
      op == cond_branch_pkg::OP_BRANCH_UNSIGNED_GE) |=> taken == !$past(flagsIn[0]))
      else $error("bad carry test");
endmodule : cond_branch_skip_unit_properties
bind cond_branch_skip_unit cond_branch_skip_unit_properties #(.PC_WIDTH(PC_WIDTH),
   .OFFSET_WIDTH(OFFSET_WIDTH)) props_i (.sys_clk(sys_clk), .rst(rst), .start(start), .op(op),
   .pcIn(pcIn), .offset(offset), .nextIsTwoWord(nextIsTwoWord), .flagsIn(flagsIn), .busy(busy),
   .done(done), .pcOut(pcOut), .taken(taken), .flagsOut(flagsOut), .cycles(cycles));
`default_nettype wire

// ==== test/cond_branch_skip_unit_bench.sv ====
// Purpose: random self-checking run of the skip/branch unit
// Assumes: 100 MHz clock, reset held 4 cycles
// Notes: bench model predicts every result
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) checkCount++; \
   if ((g) !== (e)) begin failCount++; $display("unexpected %s exp %0h got %0h", n, e, g); end
module cond_branch_skip_unit_bench;
   logic sys_clk = 0, rst = 1, start = 0, nextIsTwoWord = 0, busy, done, taken, eTk = 0;
   cond_branch_pkg::branch_op_t op = cond_branch_pkg::OP_NONE;
   logic [11:0] pcIn = 12'h000, pcOut, ePc = 12'h000;
   logic [7:0] operand = 8'h00, flagsIn = 8'h00, flagsOut, eFlags = 8'h00;
   logic [6:0] offset = 7'h00;
   logic [2:0] bitSel = 3'h0;
   logic [1:0] cycles, eCyc = 2'h0;
   int failCount = 0, checkCount = 0, seed = 83;
   always #5 sys_clk = ~sys_clk;
   cond_branch_skip_unit cond_branch_skip_unit_i (.sys_clk(sys_clk), .rst(rst), .start(start),
      .op(op), .pcIn(pcIn), .operand(operand), .bitSel(bitSel), .offset(offset),
      .nextIsTwoWord(nextIsTwoWord), .flagsIn(flagsIn), .busy(busy), .done(done),
      .pcOut(pcOut), .taken(taken), .flagsOut(flagsOut), .cycles(cycles));
   // ***************
   // model and tasks
   // ***************
   task automatic predict;
      case (int'(op))
         1, 3: eTk = !operand[bitSel];
         2, 4: eTk = operand[bitSel];
         5: eTk = flagsIn[bitSel];
         6: eTk = !flagsIn[bitSel];
         7, 8: eTk = !flagsIn[0];
         9: eTk = !(flagsIn[2] ^ flagsIn[3]);
         10: eTk = flagsIn[2] ^ flagsIn[3];
         default: eTk = flagsIn[5];
      endcase
      eFlags = flagsIn;
      if (!eTk) begin
         ePc = pcIn + 12'h001;
         eCyc = 2'h1;
      end else if (int'(op) < 5) begin
         eCyc = nextIsTwoWord ? 2'h3 : 2'h2;
         ePc = pcIn + 12'(eCyc);
      end else begin
         ePc = pcIn + 12'h001 + {{5{offset[6]}}, offset};
         eCyc = 2'h2;
      end
   endtask : predict
   task automatic compare(input logic eDone);
      `CHK("done", eDone, done)
      `CHK("taken", eTk, taken)
      `CHK("pcOut", ePc, pcOut)
      `CHK("cycles", eCyc, cycles)
      `CHK("flagsOut", eFlags, flagsOut)
   endtask : compare
   task automatic runOp(input int code);
      int n;
      op = cond_branch_pkg::branch_op_t'(code);
      pcIn = 12'($random(seed));
      operand = 8'($random(seed));
      bitSel = 3'($random(seed));
      offset = 7'($random(seed));
      nextIsTwoWord = 1'($random(seed));
      flagsIn = 8'($random(seed));
      start = 1'b1;
      if (code != 0) predict;
      @(posedge sys_clk);
      #1;
      n = 0;
      // junk requests while busy must be ignored
      while (done !== 1'b1 && n < 4) begin
         start = (busy === 1'b1) ? 1'($random(seed)) : 1'b0;
         pcIn = 12'($random(seed));
         @(posedge sys_clk);
         #1;
         n++;
      end
      compare(code != 0);
   endtask : runOp
   task automatic reportAndStop;
      $display("checks %0d mismatches %0d", checkCount, failCount);
      if (failCount == 0 && checkCount > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : reportAndStop
   initial begin
      repeat (4) @(posedge sys_clk);
      #1 rst = 1'b0;
      compare(1'b0);
      for (int i = 0; i < 240; i++) runOp(i % 12);
      start = 1'b0;
      reportAndStop;
   end
   initial begin
      #40000;
      failCount++;
      reportAndStop;
   end
endmodule : cond_branch_skip_unit_bench
`default_nettype wire
